// [verilog/adc_trig_pkg.sv]
// constants, field positions and carrier types for the converter trigger block
package adc_trig_pkg;

	// ********************************************************************
	// register offsets
	// ********************************************************************
	localparam logic [7:0] OFS_RESULT_LOW  = 8'h78; // low result byte
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h79; // high result byte
	localparam logic [7:0] OFS_CTRL_A      = 8'h7a; // control status a
	localparam logic [7:0] OFS_CTRL_B      = 8'h7b; // control status b
	localparam logic [7:0] OFS_MUX_SEL     = 8'h7c; // input mux / adjust
	localparam logic [7:0] OFS_PIN_DISABLE = 8'h7e; // digital input disable

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int BIT_A_ENABLE   = 7; // converter_enable
	localparam int BIT_A_START    = 6; // start / busy
	localparam int BIT_A_AUTO     = 5; // auto_trigger_enable
	localparam int BIT_A_FLAG     = 4; // conversion_complete_flag
	localparam int BIT_A_IRQ_EN   = 3; // interrupt enable, stored only
	localparam int BIT_B_CMP_MUX  = 6; // comparator_mux_enable
	localparam int BIT_MUX_LEFT   = 5; // left_adjust_select
	localparam int W_PRESCALE     = 3; // prescaler field width
	localparam int W_SRC          = 3; // trigger_source_select width
	localparam int W_CHAN         = 4; // channel field width
	localparam int W_REF          = 2; // reference field width
	localparam int BIT_MUX_REF_LO = 6; // reference field low bit
	localparam int W_RESULT       = 10; // converter result width
	localparam int W_DATA         = 8; // register data width

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [7:0] RST_BYTE   = 8'h00; // every register resets to zero
	localparam logic [9:0] RST_RESULT = 10'h000; // result store reset

	// ********************************************************************
	// trigger source encoding
	// ********************************************************************
	typedef enum logic [W_SRC-1:0] {
		SRC_FREE_RUN  = 3'h0, // conversion complete flag
		SRC_COMPARE   = 3'h1, // analog comparator
		SRC_EXT_INT0  = 3'h2, // external interrupt 0
		SRC_T0_CMP_A  = 3'h3, // timer0 compare a
		SRC_T0_OVF    = 3'h4, // timer0 overflow
		SRC_T1_CMP_B  = 3'h5, // timer1 compare b
		SRC_T1_OVF    = 3'h6, // timer1 overflow
		SRC_T1_CAPT   = 3'h7  // timer1 capture
	} trig_src_t;

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef struct packed {
		logic                done;  // one-cycle pulse, conversion finished
		logic [W_RESULT-1:0] value; // raw result, valid with done
	} conv_result_t;

	typedef struct packed {
		logic                  start;   // one-cycle conversion request
		logic                  enable;  // converter powered
		logic [W_PRESCALE-1:0] prescale; // clock division select
		logic [W_CHAN-1:0]     channel; // analog channel
		logic [W_REF-1:0]      refsel;  // voltage reference
	} conv_ctrl_t;

endpackage : adc_trig_pkg

// [verilog/rise_detect.sv]
// rising edge detector with a registered history bit
`timescale 1ns/1ps
module rise_detect
	import adc_trig_pkg::*;
(
	input  wire logic clk_in,    // system clock
	input  wire logic rst_in,    // async reset, active high
	input  wire logic level_in,  // level to watch
	input  wire logic mask_in,   // suppress the edge this cycle
	output logic      rise_out   // pulse on a low-to-high step
);

	logic prev_reg;  // level seen last cycle
	logic prev_next; // next history value

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb
	begin
		prev_next = level_in;
	end

	// history register
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			prev_reg <= 1'b0;
		else
			prev_reg <= prev_next;
	end

	// edge only when not masked
	assign rise_out = level_in & ~prev_reg & ~mask_in;

endmodule : rise_detect

// [verilog/adc_trigger_regs.sv]
// register and trigger control around an on-chip analog converter
`timescale 1ns/1ps
module adc_trigger_regs
	import adc_trig_pkg::*;
#(
	parameter int N_PINS = 8 // converter pins with input buffers
)
(
	input  wire logic              clk_in,          // system clock, 250 mhz
	input  wire logic              rst_in,          // async reset, active high
	input  wire logic [7:0]        addr_in,         // register address
	input  wire logic [7:0]        wdata_in,        // write data
	input  wire logic              wr_in,           // write strobe
	input  wire logic              rd_in,           // read strobe
	output logic [7:0]             rdata_out,       // read data, next cycle
	input  wire conv_result_t      conv_in,         // converter result
	output conv_ctrl_t             conv_out,        // converter control
	input  wire logic [7:1]        trig_flags_in,   // peripheral flags
	output logic                   cmp_from_mux_out, // comparator neg from mux
	output logic [N_PINS-1:0]      buf_disable_out, // input buffer off
	input  wire logic [N_PINS-1:0] pin_raw_in,      // raw pin levels
	output logic [N_PINS-1:0]      pin_read_out,    // port input bits
	output logic                   busy_out,        // conversion running
	output logic                   irq_en_out       // stored interrupt enable
);

	// ********************************************************************
	// state
	// ********************************************************************
	logic                  enable_reg,   enable_next;   // converter on
	logic                  auto_reg,     auto_next;     // auto trigger
	logic                  flag_reg,     flag_next;     // conversion complete
	logic                  ie_reg,       ie_next;       // interrupt enable
	logic [W_PRESCALE-1:0] presc_reg,    presc_next;    // prescaler
	logic                  busy_reg,     busy_next;     // conversion running
	logic                  cmux_reg,     cmux_next;     // comparator mux enable
	trig_src_t             src_reg,      src_next;      // trigger source
	logic                  left_reg,     left_next;     // left adjust
	logic [W_CHAN-1:0]     chan_reg,     chan_next;     // channel select
	logic [W_REF-1:0]      ref_reg,      ref_next;      // reference select
	logic [N_PINS-1:0]     dis_reg,      dis_next;      // buffer disables
	logic [W_RESULT-1:0]   result_reg,   result_next;   // held result
	logic                  lock_reg,     lock_next;     // low byte read
	logic [7:0]            rdata_reg,    rdata_next;    // read data
	logic                  start_reg,    start_next;    // start pulse
	logic                  cmp_reg,      cmp_next;      // comparator steering
	logic [N_PINS-1:0]     pin_reg,      pin_next;      // gated pin view

	// ********************************************************************
	// decode
	// ********************************************************************
	logic wr_a;       // write to control a
	logic wr_b;       // write to control b
	logic wr_mux;     // write to mux select
	logic wr_dis;     // write to disable register
	logic rd_low;     // read of low result byte
	logic rd_high;    // read of high result byte
	logic trig_level; // selected trigger signal
	logic trig_mask;  // hide edge caused by move to free running
	logic trig_rise;  // positive edge of trigger signal
	logic sw_start;   // software start request
	logic take_start; // conversion actually started
	logic conv_on;    // converter on once this cycle's write lands
	logic upd_result; // result store takes new value
	logic [7:0] high_view; // high byte as read
	logic [7:0] low_view;  // low byte as read

	// exact byte match on the address for each strobe
	assign wr_a    = wr_in & (addr_in == OFS_CTRL_A);
	assign wr_b    = wr_in & (addr_in == OFS_CTRL_B);
	assign wr_mux  = wr_in & (addr_in == OFS_MUX_SEL);
	assign wr_dis  = wr_in & (addr_in == OFS_PIN_DISABLE);
	assign rd_low  = rd_in & (addr_in == OFS_RESULT_LOW);
	assign rd_high = rd_in & (addr_in == OFS_RESULT_HIGH);

	// ********************************************************************
	// trigger selection
	// ********************************************************************
	// pick the flag of the selected source, nothing when auto is off
	always_comb
	begin
		trig_level = 1'b0;
		if (auto_reg)
		begin
			unique case (src_reg)
				SRC_FREE_RUN: trig_level = flag_reg;
				SRC_COMPARE:  trig_level = trig_flags_in[SRC_COMPARE];
				SRC_EXT_INT0: trig_level = trig_flags_in[SRC_EXT_INT0];
				SRC_T0_CMP_A: trig_level = trig_flags_in[SRC_T0_CMP_A];
				SRC_T0_OVF:   trig_level = trig_flags_in[SRC_T0_OVF];
				SRC_T1_CMP_B: trig_level = trig_flags_in[SRC_T1_CMP_B];
				SRC_T1_OVF:   trig_level = trig_flags_in[SRC_T1_OVF];
				SRC_T1_CAPT:  trig_level = trig_flags_in[SRC_T1_CAPT];
			endcase
		end
	end

	logic src_changed_reg;  // source was changed by a write last cycle
	logic src_changed_next; // next value

	// moving onto free running must not fire even with flag set
	assign trig_mask = (src_reg == SRC_FREE_RUN) & src_changed_reg;

	// note a rewrite that really changes the source
	always_comb
	begin
		src_changed_next = wr_b & (wdata_in[W_SRC-1:0] != src_reg);
	end

	// edge detector; a switch to a set source other than free running makes an edge too
	rise_detect u_trig_edge (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.level_in (trig_level),
		.mask_in  (trig_mask),
		.rise_out (trig_rise)
	);

	// ********************************************************************
	// conversion start and completion
	// ********************************************************************
	assign sw_start   = wr_a & wdata_in[BIT_A_START];
	// converter state as this cycle's write leaves it, so enable and
	// start may come together and a switch-off never starts
	assign conv_on    = wr_a ? wdata_in[BIT_A_ENABLE] : enable_reg;
	// start needs the converter on; edges while busy are dropped
	assign take_start = conv_on & ~busy_reg & (sw_start | trig_rise);
	// result only updates when no low byte read is pending
	assign upd_result = conv_in.done & busy_reg & enable_reg & ~lock_reg;

	// ********************************************************************
	// read views
	// ********************************************************************
	// high and low bytes for both adjust modes
	always_comb
	begin
		if (left_reg)
		begin
			high_view = result_reg[W_RESULT-1:2];
			low_view  = {result_reg[1:0], 6'h00};
		end
		else
		begin
			high_view = {6'h00, result_reg[W_RESULT-1:W_DATA]};
			low_view  = result_reg[W_DATA-1:0];
		end
	end

	// ********************************************************************
	// next state of control and result
	// ********************************************************************
	// register writes, read order lock, busy and flag updates
	always_comb
	begin
		enable_next = enable_reg;
		auto_next   = auto_reg;
		flag_next   = flag_reg;
		ie_next     = ie_reg;
		presc_next  = presc_reg;
		busy_next   = busy_reg;
		cmux_next   = cmux_reg;
		src_next    = src_reg;
		left_next   = left_reg;
		chan_next   = chan_reg;
		ref_next    = ref_reg;
		dis_next    = dis_reg;
		result_next = result_reg;
		lock_next   = lock_reg;
		// control a; start bit is not stored, busy shows instead
		if (wr_a)
		begin
			enable_next = wdata_in[BIT_A_ENABLE];
			auto_next   = wdata_in[BIT_A_AUTO];
			ie_next     = wdata_in[BIT_A_IRQ_EN];
			presc_next  = wdata_in[W_PRESCALE-1:0];
			// write one clears the flag
			if (wdata_in[BIT_A_FLAG])
				flag_next = 1'b0;
		end
		// control b keeps only its defined bits
		if (wr_b)
		begin
			cmux_next = wdata_in[BIT_B_CMP_MUX];
			src_next  = trig_src_t'(wdata_in[W_SRC-1:0]);
		end
		if (wr_mux)
		begin
			ref_next  = wdata_in[BIT_MUX_REF_LO +: W_REF];
			left_next = wdata_in[BIT_MUX_LEFT];
			chan_next = wdata_in[W_CHAN-1:0];
		end
		if (wr_dis)
			dis_next = wdata_in[N_PINS-1:0];
		// read order lock: low freezes, high releases
		if (rd_low)
			lock_next = 1'b1;
		if (rd_high)
			lock_next = 1'b0;
		// busy tracking
		if (take_start)
			busy_next = 1'b1;
		else if (conv_in.done)
			busy_next = 1'b0;
		// switching the converter off ends any conversion
		if (wr_a & ~wdata_in[BIT_A_ENABLE])
			busy_next = 1'b0;
		// result update sets the flag; set wins over clear
		if (upd_result)
		begin
			result_next = conv_in.value;
			flag_next   = 1'b1;
		end
	end

	// ********************************************************************
	// next state of bus and outputs
	// ********************************************************************
	// read data for one cycle, zero otherwise; pin view and steering
	always_comb
	begin
		rdata_next = RST_BYTE;
		if (rd_in)
		begin
			unique case (addr_in)
				OFS_RESULT_LOW:  rdata_next = low_view;
				OFS_RESULT_HIGH: rdata_next = high_view;
				OFS_CTRL_A:
				begin
					rdata_next[BIT_A_ENABLE]     = enable_reg;
					rdata_next[BIT_A_START]      = busy_reg;
					rdata_next[BIT_A_AUTO]       = auto_reg;
					rdata_next[BIT_A_FLAG]       = flag_reg;
					rdata_next[BIT_A_IRQ_EN]     = ie_reg;
					rdata_next[W_PRESCALE-1:0]   = presc_reg;
				end
				OFS_CTRL_B:
				begin
					rdata_next[BIT_B_CMP_MUX] = cmux_reg;
					rdata_next[W_SRC-1:0]     = src_reg;
				end
				OFS_MUX_SEL:
				begin
					rdata_next[BIT_MUX_REF_LO +: W_REF] = ref_reg;
					rdata_next[BIT_MUX_LEFT]            = left_reg;
					rdata_next[W_CHAN-1:0]              = chan_reg;
				end
				OFS_PIN_DISABLE: rdata_next[N_PINS-1:0] = dis_reg;
				default:         rdata_next = RST_BYTE; // unmapped reads zero
			endcase
		end
		// start pulse one cycle after the accepted request
		start_next = take_start;
		// comparator negative input from mux only when converter off
		cmp_next   = cmux_reg & ~enable_reg;
		// disabled pins read as zero
		pin_next   = pin_raw_in & ~dis_reg;
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	// all state registers, cleared by the asynchronous reset
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			enable_reg      <= 1'b0;
			auto_reg        <= 1'b0;
			flag_reg        <= 1'b0;
			ie_reg          <= 1'b0;
			presc_reg       <= '0;
			busy_reg        <= 1'b0;
			cmux_reg        <= 1'b0;
			src_reg         <= SRC_FREE_RUN;
			src_changed_reg <= 1'b0;
			left_reg        <= 1'b0;
			chan_reg        <= '0;
			ref_reg         <= '0;
			dis_reg         <= '0;
			result_reg      <= RST_RESULT;
			lock_reg        <= 1'b0;
			rdata_reg       <= RST_BYTE;
			start_reg       <= 1'b0;
			cmp_reg         <= 1'b0;
			pin_reg         <= '0;
		end
		else
		begin
			enable_reg      <= enable_next;
			auto_reg        <= auto_next;
			flag_reg        <= flag_next;
			ie_reg          <= ie_next;
			presc_reg       <= presc_next;
			busy_reg        <= busy_next;
			cmux_reg        <= cmux_next;
			src_reg         <= src_next;
			src_changed_reg <= src_changed_next;
			left_reg        <= left_next;
			chan_reg        <= chan_next;
			ref_reg         <= ref_next;
			dis_reg         <= dis_next;
			result_reg      <= result_next;
			lock_reg        <= lock_next;
			rdata_reg       <= rdata_next;
			start_reg       <= start_next;
			cmp_reg         <= cmp_next;
			pin_reg         <= pin_next;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	// every output straight from a register above
	assign rdata_out         = rdata_reg;
	assign conv_out.start    = start_reg;
	assign conv_out.enable   = enable_reg;
	assign conv_out.prescale = presc_reg;
	assign conv_out.channel  = chan_reg;
	assign conv_out.refsel   = ref_reg;
	assign cmp_from_mux_out  = cmp_reg;
	assign buf_disable_out   = dis_reg;
	assign pin_read_out      = pin_reg;
	assign busy_out          = busy_reg;
	assign irq_en_out        = ie_reg;

endmodule : adc_trigger_regs

// [dv/adc_trig_assertions.sv]
// concurrent checks on the ports of the converter trigger block
`timescale 1ns/1ps
module adc_trig_assertions
	import adc_trig_pkg::*;
#(
	parameter int N_PINS = 8 // converter pins with input buffers
)
(
	input wire logic              clk_in,
	input wire logic              rst_in,
	input wire logic [7:0]        addr_in,
	input wire logic [7:0]        wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [7:0]        rdata_out,
	input wire conv_result_t      conv_in,
	input wire conv_ctrl_t        conv_out,
	input wire logic [7:1]        trig_flags_in,
	input wire logic              cmp_from_mux_out,
	input wire logic [N_PINS-1:0] buf_disable_out,
	input wire logic [N_PINS-1:0] pin_read_out,
	input wire logic              busy_out
);
	// **********
	// shadow of the written control bits
	// **********
	logic       auto_reg;  // auto trigger enable
	logic       auto_next;
	logic       cmux_reg;  // comparator mux enable
	logic       cmux_next;
	logic [2:0] src_reg;   // trigger source
	logic [2:0] src_next;
	logic       sel;       // selected peripheral flag, none in free run
	logic       start_wr;  // software start request

	assign sel = (src_reg == 3'h0) ? 1'b0 : trig_flags_in[src_reg];
	assign start_wr = wr_in && addr_in == OFS_CTRL_A && wdata_in[BIT_A_START];

	// next values follow register writes
	always_comb
	begin
		auto_next = auto_reg;
		cmux_next = cmux_reg;
		src_next = src_reg;
		if (wr_in && addr_in == OFS_CTRL_A)
			auto_next = wdata_in[BIT_A_AUTO];
		if (wr_in && addr_in == OFS_CTRL_B)
		begin
			cmux_next = wdata_in[BIT_B_CMP_MUX];
			src_next = wdata_in[2:0];
		end
	end

	// shadow registers clear with the block
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			auto_reg <= 1'b0;
			cmux_reg <= 1'b0;
			src_reg <= 3'h0;
		end
		else
		begin
			auto_reg <= auto_next;
			cmux_reg <= cmux_next;
			src_reg <= src_next;
		end
	end

	// **********
	// properties
	// **********
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// switch to free running away from another source
	sequence s_free_sel;
		wr_in && addr_in == OFS_CTRL_B && wdata_in[2:0] == 3'h0 && src_reg != 3'h0;
	endsequence
	// selected flag steps up while a start can be taken
	sequence s_trig_rise;
		conv_out.enable && !busy_out && auto_reg && !wr_in && src_reg != 3'h0
			&& $past(src_reg) != 3'h0 && !$past(sel) && sel;
	endsequence

	AST_PIN_ZERO: assert property (
		(pin_read_out & buf_disable_out & $past(buf_disable_out)) == '0)
		else $error("disabled pin reads one");
	AST_BUF_WRITE: assert property (
		wr_in && addr_in == OFS_PIN_DISABLE |=> buf_disable_out == $past(wdata_in[N_PINS-1:0]))
		else $error("buffer disable not written");
	AST_CMUX: assert property (
		$stable(conv_out.enable) && $stable(cmux_reg)
			|-> cmp_from_mux_out == (cmux_reg && !conv_out.enable))
		else $error("comparator input select wrong");
	AST_START_PULSE: assert property (
		conv_out.start |-> busy_out ##1 !conv_out.start)
		else $error("start not a single pulse with busy");
	AST_NO_AUTO: assert property (
		conv_out.start |-> $past(start_wr) || $past(auto_reg))
		else $error("start without request or auto trigger");
	AST_TRIG_RISE: assert property (
		s_trig_rise |=> conv_out.start)
		else $error("selected flag rise gave no start");
	AST_FREE_MUTE: assert property (
		s_free_sel ##1 !(wr_in && addr_in == OFS_CTRL_A) |=> !conv_out.start)
		else $error("free running selection triggered");
	AST_CTRLB_UNUSED: assert property (
		rd_in && addr_in == OFS_CTRL_B |=> rdata_out[7] == 1'b0 && rdata_out[5:3] == 3'h0)
		else $error("unused control b bits read one");
	AST_BUSY_END: assert property (
		busy_out && conv_in.done |=> !busy_out)
		else $error("busy stayed after completion");
endmodule : adc_trig_assertions

bind adc_trigger_regs adc_trig_assertions #(.N_PINS(N_PINS)) adc_trig_assertions_i (
	.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .conv_in(conv_in),
	.conv_out(conv_out), .trig_flags_in(trig_flags_in), .cmp_from_mux_out(cmp_from_mux_out),
	.buf_disable_out(buf_disable_out), .pin_read_out(pin_read_out), .busy_out(busy_out));

// [dv/conv_far_model.sv]
// behavioural converter answering start pulses after a set delay
`timescale 1ns/1ps
module conv_far_model
	import adc_trig_pkg::*;
(
	input  wire logic       clk_in,   // system clock
	input  wire logic       rst_in,   // async reset, active high
	input  wire conv_ctrl_t ctrl_in,  // requests from the block
	input  wire logic [9:0] value_in, // result handed back next
	input  wire logic [7:0] delay_in, // conversion length, two or more
	output conv_result_t    res_out   // done pulse with result
);
	// **********
	// conversion timer
	// **********
	logic [7:0]   cnt_reg;  // cycles left, zero when idle
	logic [7:0]   cnt_next;
	conv_result_t res_next;

	// next state: load on start, abort on power off
	always_comb
	begin
		cnt_next = cnt_reg;
		res_next.done = 1'b0;
		res_next.value = ~res_out.value; // no valid data: value keeps moving
		if (!ctrl_in.enable)
			cnt_next = 8'h00;
		else if (ctrl_in.start)
			cnt_next = delay_in;
		else if (cnt_reg == 8'h01)
		begin
			res_next.done = 1'b1;
			res_next.value = value_in;
			cnt_next = 8'h00;
		end
		else if (cnt_reg != 8'h00)
			cnt_next = cnt_reg - 8'h01;
	end

	// registers only
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_reg <= 8'h00;
			res_out <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			res_out <= res_next;
		end
	end
endmodule : conv_far_model

// [dv/test_adc_trigger_regs.sv]
// self-checking bench for the converter trigger block
`timescale 1ns/1ps
module test_adc_trigger_regs;
	import adc_trig_pkg::*;
	logic clk_in, rst_in, wr_in, rd_in, cmp_from_mux_out, busy_out, irq_en_out;
	logic [7:0] addr_in, wdata_in, rdata_out, buf_disable_out, pin_raw_in, pin_read_out;
	logic [7:1] trig_flags_in; // peripheral flag levels
	logic [9:0] res_val;       // next converter result
	logic [7:0] res_dly;       // converter delay
	conv_result_t conv_in;
	conv_ctrl_t conv_out;
	int bad_count = 0;
	int comparisons = 0;
	int s;
	logic [7:0] pat [2] = '{8'ha5, 8'h5a}; // disable patterns

	adc_trigger_regs #(.N_PINS(8)) adc_trigger_regs_i (.clk_in(clk_in), .rst_in(rst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .conv_in(conv_in), .conv_out(conv_out),
		.trig_flags_in(trig_flags_in), .cmp_from_mux_out(cmp_from_mux_out),
		.buf_disable_out(buf_disable_out), .pin_raw_in(pin_raw_in),
		.pin_read_out(pin_read_out), .busy_out(busy_out), .irq_en_out(irq_en_out));
	conv_far_model conv_far_model_i (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in(conv_out),
		.value_in(res_val), .delay_in(res_dly), .res_out(conv_in));

	// **********
	// helpers
	// **********
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(name, exp, rdata_out);
	endtask : rd

	// looks for a start pulse over n cycles
	task automatic watch(input int n, input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge clk_in);
			#1;
			if (conv_out.start === 1'b1)
				seen = 1'b1;
		end
		chk("start", 8'(exp), 8'(seen));
	endtask : watch

	// bounded wait for the conversion to end
	task automatic wait_idle;
		int i;
		i = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			i++;
		end
		while (busy_out !== 1'b0 && i < 64);
		chk("busy", 8'h00, 8'(busy_out));
	endtask : wait_idle

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// **********
	// clock, watchdog, tests
	// **********
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	initial
	begin
		#100000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		rst_in = 1'b1;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		trig_flags_in = 7'h00;
		pin_raw_in = 8'hff;
		res_val = 10'h000;
		res_dly = 8'h04;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(8'h79, 8'h00, "high");
		rd(8'h7b, 8'h00, "ctrl_b");
		rd(8'h7d, 8'h00, "unmapped");
		foreach (pat[i])
		begin
			wr(8'h7e, pat[i]);
			#1;
			chk("buf_off", pat[i], buf_disable_out);
			@(posedge clk_in);
			#1;
			chk("pin_read", ~pat[i], pin_read_out);
			rd(8'h7e, pat[i], "disable");
		end
		wr(8'h7b, 8'hff);
		rd(8'h7b, 8'h47, "ctrl_b");
		chk("cmp_mux", 8'h01, 8'(cmp_from_mux_out));
		wr(8'h7a, 8'h80);
		repeat (2) @(posedge clk_in);
		#1;
		chk("cmp_mux", 8'h00, 8'(cmp_from_mux_out));
		wr(8'h7b, 8'h00);
		wr(8'h7c, 8'h20);
		res_val <= 10'h2b5;
		wr(8'h7a, 8'hc0);
		wait_idle();
		rd(8'h79, 8'had, "high_left");
		rd(8'h7a, 8'h90, "ctrl_a");
		wr(8'h7a, 8'h90);
		wr(8'h7c, 8'h00);
		rd(8'h78, 8'hb5, "low");
		res_val <= 10'h3ff;
		wr(8'h7a, 8'hc0);
		wait_idle();
		rd(8'h7a, 8'h80, "ctrl_a");
		rd(8'h79, 8'h02, "high");
		res_val <= 10'h155;
		wr(8'h7a, 8'hc0);
		wait_idle();
		rd(8'h79, 8'h01, "high");
		wr(8'h7a, 8'h80);
		wr(8'h7b, 8'h01);
		trig_flags_in[1] <= 1'b1;
		watch(6, 1'b0);
		trig_flags_in <= 7'h00;
		wr(8'h7a, 8'ha0);
		for (s = 1; s < 8; s++)
		begin
			wr(8'h7b, 8'(s));
			trig_flags_in[s] <= 1'b1;
			watch(4, 1'b1);
			wait_idle();
			trig_flags_in <= 7'h00;
		end
		wr(8'h7b, 8'h01);
		trig_flags_in[2] <= 1'b1;
		watch(3, 1'b0);
		wr(8'h7b, 8'h02);
		watch(4, 1'b1);
		wait_idle();
		wr(8'h7b, 8'h01);
		rd(8'h7a, 8'hb0, "ctrl_a");
		wr(8'h7b, 8'h00);
		watch(6, 1'b0);
		wr(8'h7a, 8'hb0);
		wr(8'h7a, 8'he0);
		watch(10, 1'b1);
		wait_idle();
		rd(8'h7a, 8'hb0, "ctrl_a");
		wr(8'h7a, 8'h00);
		wait_idle();
		wr(8'h7a, 8'h0b);
		wr(8'h7c, 8'hc5);
		#1;
		chk("irq_en", 8'h01, 8'(irq_en_out));
		chk("prescale", 8'h03, 8'(conv_out.prescale));
		chk("channel", 8'h05, 8'(conv_out.channel));
		chk("refsel", 8'h03, 8'(conv_out.refsel));
		rd(8'h7c, 8'hc5, "mux_sel");
		print_verdict();
	end
endmodule : test_adc_trigger_regs
